// ==== src/sdram_cmd_pkg.sv ====
// Package: command codes and widths shared by both ends, and the decoder's precharge timing
package sdram_cmd_pkg;
	localparam int bank_bits = 3;
	localparam int banks = 8;
	localparam int addr_bits = 13;
	localparam int ap_pos = 10;
	localparam int bc_pos = 12;
	localparam int clk_period_ps = 5000;
	// Precharge period in picoseconds, rounded up to cycles
	localparam int precharge_period_ps = 13750;
	localparam int precharge_cycles =
		(precharge_period_ps + clk_period_ps - 1) / clk_period_ps;
	localparam int pre_cnt_bits = 4;

	// Command strobe codes {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] code_activate = 4'h3;
	localparam logic [3:0] code_precharge = 4'h2;
	localparam logic [3:0] code_write = 4'h4;
	localparam logic [3:0] code_read = 4'h5;
	localparam logic [3:0] code_mode_write = 4'h0;
	localparam logic [3:0] code_refresh = 4'h1;
	localparam logic [3:0] code_no_operation = 4'h7;
	localparam logic [3:0] code_calibrate = 4'h6;

	typedef enum logic [3:0] {
		cmd_none = 4'h0,
		cmd_activate = 4'h1,
		cmd_precharge = 4'h2,
		cmd_precharge_all = 4'h3,
		cmd_write = 4'h4,
		cmd_read = 4'h5,
		cmd_mode_write = 4'h6,
		cmd_refresh = 4'h7,
		cmd_self_refresh = 4'h8,
		cmd_power_down = 4'h9,
		cmd_wake = 4'ha,
		cmd_cal_long = 4'hb,
		cmd_cal_short = 4'hc,
		cmd_illegal = 4'hd
	} cmd_type;

	// Power state; gray along normal -> power down -> normal, not via self refresh
	typedef enum logic [1:0] {
		pwr_normal = 2'h0,
		pwr_power_down = 2'h1,
		pwr_self_refresh = 2'h3
	} pwr_type;
endpackage

// ==== src/sdram_cmd_if.sv ====
// Interface: command pins between controller and device decoder
interface sdram_cmd_if;
	logic cke;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [sdram_cmd_pkg::bank_bits-1:0] bank_select;
	logic [sdram_cmd_pkg::addr_bits-1:0] addr;
	logic lower_byte_mask;
	logic upper_byte_mask;

	modport controller (output cke, cs_n, ras_n, cas_n, we_n,
		bank_select, addr, lower_byte_mask, upper_byte_mask);
	modport device (input cke, cs_n, ras_n, cas_n, we_n,
		bank_select, addr, lower_byte_mask, upper_byte_mask);
endinterface

// ==== src/sdram_command_decoder.sv ====
// Device end: command decoder with per-bank row state
module sdram_command_decoder #(
	parameter int banks = sdram_cmd_pkg::banks,
	parameter int precharge_cycles = sdram_cmd_pkg::precharge_cycles
) (
	input wire logic mclk,
	input wire logic arst_n,
	sdram_cmd_if.device pins,
	input wire logic burst_otf_en,
	output sdram_cmd_pkg::cmd_type cmd,
	output logic cmd_valid,
	output logic [sdram_cmd_pkg::bank_bits-1:0] cmd_bank,
	output logic [sdram_cmd_pkg::addr_bits-1:0] cmd_addr,
	output logic cmd_auto_precharge,
	output logic cmd_chopped_four_beat_burst,
	output logic [1:0] write_lane_enable,
	output logic [banks-1:0] bank_active,
	output logic [banks-1:0] bank_ready,
	output logic [sdram_cmd_pkg::addr_bits-1:0] open_row [banks],
	output sdram_cmd_pkg::pwr_type power_state
);
	localparam int pcb = sdram_cmd_pkg::pre_cnt_bits;
	localparam logic [pcb-1:0] pre_load = pcb'(precharge_cycles);

	// =====================================================
	// Input registers
	logic cke_q, cke_prev_q, cs_n_q, ras_n_q, cas_n_q, we_n_q;
	logic [sdram_cmd_pkg::bank_bits-1:0] ba_q;
	logic [sdram_cmd_pkg::addr_bits-1:0] a_q;
	logic [1:0] mask_q;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cke_q <= 1'b0;
			cke_prev_q <= 1'b0;
			cs_n_q <= 1'b1;
			ras_n_q <= 1'b1;
			cas_n_q <= 1'b1;
			we_n_q <= 1'b1;
			ba_q <= '0;
			a_q <= '0;
			mask_q <= 2'h3;
		end else begin
			cke_q <= pins.cke;
			cke_prev_q <= cke_q;
			cs_n_q <= pins.cs_n;
			ras_n_q <= pins.ras_n;
			cas_n_q <= pins.cas_n;
			we_n_q <= pins.we_n;
			ba_q <= pins.bank_select;
			a_q <= pins.addr;
			mask_q <= {pins.upper_byte_mask, pins.lower_byte_mask};
		end
	end

	// =====================================================
	// Decode
	logic [3:0] code;
	logic all_idle, sel_active, sel_ready, quiet, cke_hh;
	sdram_cmd_pkg::cmd_type dec;
	sdram_cmd_pkg::pwr_type pwr_q;

	assign code = {cs_n_q, ras_n_q, cas_n_q, we_n_q};
	assign all_idle = ~|bank_active && &bank_ready;
	assign sel_active = bank_active[ba_q];
	assign sel_ready = bank_ready[ba_q];
	// Deselect or no-operation
	assign quiet = cs_n_q || code == sdram_cmd_pkg::code_no_operation;
	assign cke_hh = cke_prev_q && cke_q;

	always_comb begin
		dec = sdram_cmd_pkg::cmd_none;
		if (pwr_q != sdram_cmd_pkg::pwr_normal) begin
			if (cke_q && quiet) begin
				dec = sdram_cmd_pkg::cmd_wake;
			end
		end else if (cke_prev_q && !cke_q) begin
			if (quiet) begin
				dec = sdram_cmd_pkg::cmd_power_down;
			end else if (code == sdram_cmd_pkg::code_refresh && all_idle) begin
				dec = sdram_cmd_pkg::cmd_self_refresh;
			end else begin
				dec = sdram_cmd_pkg::cmd_illegal;
			end
		end else if (cke_hh && !cs_n_q) begin
			unique case (code)
				sdram_cmd_pkg::code_activate:
					dec = (!sel_active && sel_ready) ?
						sdram_cmd_pkg::cmd_activate : sdram_cmd_pkg::cmd_illegal;
				sdram_cmd_pkg::code_precharge:
					dec = a_q[sdram_cmd_pkg::ap_pos] ?
						sdram_cmd_pkg::cmd_precharge_all :
						sdram_cmd_pkg::cmd_precharge;
				sdram_cmd_pkg::code_write:
					dec = sel_active ? sdram_cmd_pkg::cmd_write :
						sdram_cmd_pkg::cmd_illegal;
				sdram_cmd_pkg::code_read:
					dec = sel_active ? sdram_cmd_pkg::cmd_read :
						sdram_cmd_pkg::cmd_illegal;
				sdram_cmd_pkg::code_mode_write:
					dec = all_idle ? sdram_cmd_pkg::cmd_mode_write :
						sdram_cmd_pkg::cmd_illegal;
				sdram_cmd_pkg::code_refresh:
					dec = all_idle ? sdram_cmd_pkg::cmd_refresh :
						sdram_cmd_pkg::cmd_illegal;
				sdram_cmd_pkg::code_calibrate:
					dec = !all_idle ? sdram_cmd_pkg::cmd_illegal :
						a_q[sdram_cmd_pkg::ap_pos] ? sdram_cmd_pkg::cmd_cal_long :
						sdram_cmd_pkg::cmd_cal_short;
				default: dec = sdram_cmd_pkg::cmd_none;
			endcase
		end
	end

	// =====================================================
	// Command output register
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cmd <= sdram_cmd_pkg::cmd_none;
			cmd_valid <= 1'b0;
			cmd_bank <= '0;
			cmd_addr <= '0;
			cmd_auto_precharge <= 1'b0;
			cmd_chopped_four_beat_burst <= 1'b0;
			write_lane_enable <= 2'h0;
		end else begin
			cmd <= dec;
			cmd_valid <= dec != sdram_cmd_pkg::cmd_none;
			cmd_bank <= ba_q;
			cmd_addr <= a_q;
			cmd_auto_precharge <= a_q[sdram_cmd_pkg::ap_pos];
			cmd_chopped_four_beat_burst <= burst_otf_en &&
				!a_q[sdram_cmd_pkg::bc_pos];
			write_lane_enable <= (cke_prev_q && |bank_active) ?
				~mask_q : 2'h0;
		end
	end

	// =====================================================
	// Power state
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pwr_q <= sdram_cmd_pkg::pwr_normal;
		end else if (dec == sdram_cmd_pkg::cmd_power_down) begin
			pwr_q <= sdram_cmd_pkg::pwr_power_down;
		end else if (dec == sdram_cmd_pkg::cmd_self_refresh) begin
			pwr_q <= sdram_cmd_pkg::pwr_self_refresh;
		end else if (dec == sdram_cmd_pkg::cmd_wake) begin
			pwr_q <= sdram_cmd_pkg::pwr_normal;
		end
	end
	assign power_state = pwr_q;

	// =====================================================
	// Per-bank row state and precharge timers
	for (genvar b = 0; b < banks; b++) begin : g_bank
		logic act_q;
		logic [pcb-1:0] cnt_q;
		logic [sdram_cmd_pkg::addr_bits-1:0] row_q;
		logic hit, pre_hit;
		assign hit = int'(ba_q) == b;
		assign pre_hit = dec == sdram_cmd_pkg::cmd_precharge_all ||
			(dec == sdram_cmd_pkg::cmd_precharge && hit);

		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				act_q <= 1'b0;
				row_q <= '0;
			end else if (dec == sdram_cmd_pkg::cmd_activate && hit) begin
				act_q <= 1'b1;
				row_q <= a_q;
			end else if (pre_hit) begin
				act_q <= 1'b0;
			end
		end

		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				cnt_q <= '0;
			end else if (pre_hit) begin
				cnt_q <= pre_load;
			end else if (cnt_q != '0) begin
				cnt_q <= cnt_q - pcb'(1);
			end
		end

		assign bank_active[b] = act_q;
		assign bank_ready[b] = cnt_q == '0;
		assign open_row[b] = row_q;
	end
endmodule // sdram_command_decoder

// ==== src/sdram_command_issuer.sv ====
// Controller end: drives one requested command onto the pins
module sdram_command_issuer (
	input wire logic mclk,
	input wire logic arst_n,
	sdram_cmd_if.controller pins,
	input wire logic req_valid,
	output logic req_ready,
	input wire sdram_cmd_pkg::cmd_type req_cmd,
	input wire logic [sdram_cmd_pkg::bank_bits-1:0] req_bank,
	input wire logic [sdram_cmd_pkg::addr_bits-1:0] req_addr,
	input wire logic req_auto_precharge,
	input wire logic req_chop,
	input wire logic [1:0] req_lane_mask
);
	logic [3:0] code_d;
	logic cke_d, take;
	logic [sdram_cmd_pkg::addr_bits-1:0] addr_d;
	logic cke_q;

	assign req_ready = 1'b1;
	assign take = req_valid;

	always_comb begin
		code_d = sdram_cmd_pkg::code_no_operation;
		cke_d = cke_q;
		addr_d = req_addr;
		unique case (req_cmd)
			sdram_cmd_pkg::cmd_activate: code_d = sdram_cmd_pkg::code_activate;
			sdram_cmd_pkg::cmd_precharge, sdram_cmd_pkg::cmd_precharge_all: begin
				code_d = sdram_cmd_pkg::code_precharge;
				addr_d[sdram_cmd_pkg::ap_pos] =
					req_cmd == sdram_cmd_pkg::cmd_precharge_all;
			end
			sdram_cmd_pkg::cmd_write, sdram_cmd_pkg::cmd_read: begin
				code_d = req_cmd == sdram_cmd_pkg::cmd_write ?
					sdram_cmd_pkg::code_write : sdram_cmd_pkg::code_read;
				addr_d[sdram_cmd_pkg::ap_pos] = req_auto_precharge;
				addr_d[sdram_cmd_pkg::bc_pos] = !req_chop;
			end
			sdram_cmd_pkg::cmd_mode_write: code_d = sdram_cmd_pkg::code_mode_write;
			sdram_cmd_pkg::cmd_refresh: code_d = sdram_cmd_pkg::code_refresh;
			sdram_cmd_pkg::cmd_self_refresh: begin
				code_d = sdram_cmd_pkg::code_refresh;
				cke_d = 1'b0;
			end
			sdram_cmd_pkg::cmd_power_down: cke_d = 1'b0;
			sdram_cmd_pkg::cmd_wake: cke_d = 1'b1;
			sdram_cmd_pkg::cmd_cal_long, sdram_cmd_pkg::cmd_cal_short: begin
				code_d = sdram_cmd_pkg::code_calibrate;
				addr_d[sdram_cmd_pkg::ap_pos] =
					req_cmd == sdram_cmd_pkg::cmd_cal_long;
			end
			default: code_d = sdram_cmd_pkg::code_no_operation;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cke_q <= 1'b0;
			{pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'hf;
			pins.bank_select <= '0;
			pins.addr <= '0;
			pins.lower_byte_mask <= 1'b1;
			pins.upper_byte_mask <= 1'b1;
		end else begin
			if (take) begin
				cke_q <= cke_d;
				{pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= code_d;
				pins.bank_select <= req_bank;
				pins.addr <= addr_d;
			end else begin
				cke_q <= cke_q;
				{pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'hf;
			end
			pins.lower_byte_mask <= req_lane_mask[0];
			pins.upper_byte_mask <= req_lane_mask[1];
		end
	end
	assign pins.cke = cke_q;
endmodule // sdram_command_issuer

// ==== verification/sdram_cmd_checker.sv ====
// Checker: pin-level command and clock gate rules on the link
module sdram_cmd_checker (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [sdram_cmd_pkg::bank_bits-1:0] bank_select,
	input wire logic [sdram_cmd_pkg::addr_bits-1:0] addr,
	input wire logic lower_byte_mask,
	input wire logic upper_byte_mask
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] code;

	assign code = {cs_n, ras_n, cas_n, we_n};

	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);

	// ==========================================================
	// Sequences and properties
	sequence s_cke_held;
		cke && $past(cke);
	endsequence
	sequence s_cke_drop;
		$past(cke) && !cke;
	endsequence
	sequence s_cke_lift;
		!$past(cke) && cke;
	endsequence

	property p_activate;
		code == sdram_cmd_pkg::code_activate |-> s_cke_held;
	endproperty
	property p_precharge;
		code == sdram_cmd_pkg::code_precharge |-> s_cke_held;
	endproperty
	property p_write;
		code == sdram_cmd_pkg::code_write |-> s_cke_held;
	endproperty
	property p_read;
		code == sdram_cmd_pkg::code_read |-> s_cke_held;
	endproperty
	property p_mode;
		code == sdram_cmd_pkg::code_mode_write |-> s_cke_held;
	endproperty
	property p_calibrate;
		code == sdram_cmd_pkg::code_calibrate |-> s_cke_held;
	endproperty
	property p_refresh;
		code == sdram_cmd_pkg::code_refresh |-> $past(cke);
	endproperty
	property p_enter;
		s_cke_drop |-> cs_n || code == sdram_cmd_pkg::code_no_operation
			|| code == sdram_cmd_pkg::code_refresh;
	endproperty
	property p_exit;
		s_cke_lift |-> cs_n || code == sdram_cmd_pkg::code_no_operation;
	endproperty
	property p_asleep;
		!cke && !$past(cke) |-> cs_n
			|| code == sdram_cmd_pkg::code_no_operation;
	endproperty

	a_activate: assert property (p_activate)
		else $error("activate without clock gate held high");
	a_precharge: assert property (p_precharge)
		else $error("precharge without clock gate held high");
	a_write: assert property (p_write)
		else $error("write without clock gate held high");
	a_read: assert property (p_read)
		else $error("read without clock gate held high");
	a_mode: assert property (p_mode)
		else $error("mode write without clock gate held high");
	a_calibrate: assert property (p_calibrate)
		else $error("calibration without clock gate held high");
	a_refresh: assert property (p_refresh)
		else $error("refresh code after clock gate low");
	a_enter: assert property (p_enter)
		else $error("clock gate fell with a wrong command");
	a_exit: assert property (p_exit)
		else $error("clock gate rose with a wrong command");
	a_asleep: assert property (p_asleep)
		else $error("command issued while clock gate low");
endmodule // sdram_cmd_checker

// ==== verification/tb_top.sv ====
// Testbench: issuer and decoder joined over the command link
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		sdram_cmd_pkg::cmd_type c;
		logic [2:0] b;
		logic ap, ch, bad;
	} row_type;
	logic mclk, arst_n, burst_otf_en, req_valid, req_ready;
	logic req_auto_precharge, req_chop, cmd_valid, cmd_auto_precharge;
	logic cmd_chopped_four_beat_burst;
	logic [1:0] req_lane_mask, write_lane_enable;
	logic [2:0] req_bank, cmd_bank;
	logic [12:0] req_addr, cmd_addr;
	logic [12:0] open_row [8];
	logic [7:0] bank_active, bank_ready;
	sdram_cmd_pkg::cmd_type req_cmd, cmd;
	sdram_cmd_pkg::pwr_type power_state;
	int num_errors = 0;
	int checked = 0;
	row_type rows [17] = '{
		'{sdram_cmd_pkg::cmd_activate, 3'h2, 1'b0, 1'b0, 1'b0},
		'{sdram_cmd_pkg::cmd_write, 3'h2, 1'b0, 1'b1, 1'b0},
		'{sdram_cmd_pkg::cmd_read, 3'h2, 1'b0, 1'b0, 1'b0},
		'{sdram_cmd_pkg::cmd_read, 3'h5, 1'b0, 1'b0, 1'b1},
		'{sdram_cmd_pkg::cmd_mode_write, 3'h1, 1'b0, 1'b0, 1'b1},
		'{sdram_cmd_pkg::cmd_precharge, 3'h2, 1'b0, 1'b0, 1'b0},
		'{sdram_cmd_pkg::cmd_precharge, 3'h2, 1'b0, 1'b0, 1'b0},
		'{sdram_cmd_pkg::cmd_mode_write, 3'h1, 1'b0, 1'b0, 1'b0},
		'{sdram_cmd_pkg::cmd_cal_long, 3'h0, 1'b1, 1'b0, 1'b0},
		'{sdram_cmd_pkg::cmd_cal_short, 3'h0, 1'b0, 1'b0, 1'b0},
		'{sdram_cmd_pkg::cmd_refresh, 3'h0, 1'b0, 1'b0, 1'b0},
		'{sdram_cmd_pkg::cmd_activate, 3'h3, 1'b0, 1'b0, 1'b0},
		'{sdram_cmd_pkg::cmd_write, 3'h3, 1'b1, 1'b0, 1'b0},
		'{sdram_cmd_pkg::cmd_activate, 3'h4, 1'b0, 1'b0, 1'b0},
		'{sdram_cmd_pkg::cmd_read, 3'h4, 1'b1, 1'b1, 1'b0},
		'{sdram_cmd_pkg::cmd_precharge_all, 3'h0, 1'b1, 1'b0, 1'b0},
		'{sdram_cmd_pkg::cmd_read, 3'h3, 1'b0, 1'b0, 1'b1}};
	sdram_cmd_pkg::cmd_type lp [4] = '{sdram_cmd_pkg::cmd_power_down,
		sdram_cmd_pkg::cmd_wake, sdram_cmd_pkg::cmd_self_refresh,
		sdram_cmd_pkg::cmd_wake};
	sdram_cmd_pkg::pwr_type lps [4] = '{sdram_cmd_pkg::pwr_power_down,
		sdram_cmd_pkg::pwr_normal, sdram_cmd_pkg::pwr_self_refresh,
		sdram_cmd_pkg::pwr_normal};

	sdram_cmd_if link ();
	sdram_command_issuer sdram_command_issuer_i (.mclk, .arst_n,
		.pins(link), .req_valid, .req_ready, .req_cmd, .req_bank,
		.req_addr, .req_auto_precharge, .req_chop, .req_lane_mask);
	sdram_command_decoder sdram_command_decoder_i (.mclk, .arst_n,
		.pins(link), .burst_otf_en, .cmd, .cmd_valid, .cmd_bank,
		.cmd_addr, .cmd_auto_precharge, .cmd_chopped_four_beat_burst,
		.write_lane_enable, .bank_active, .bank_ready, .open_row,
		.power_state);
	sdram_cmd_checker sdram_cmd_checker_i (.mclk, .arst_n,
		.cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
		.cas_n(link.cas_n), .we_n(link.we_n),
		.bank_select(link.bank_select), .addr(link.addr),
		.lower_byte_mask(link.lower_byte_mask),
		.upper_byte_mask(link.upper_byte_mask));

	// ==========================================================
	// Tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Decode shows two edges after the request is taken
	task automatic issue(input sdram_cmd_pkg::cmd_type c,
		input logic [2:0] b, input logic ap, input logic ch);
		@(posedge mclk);
		#1;
		req_valid = 1'b1;
		req_cmd = c;
		req_bank = b;
		req_auto_precharge = ap;
		req_chop = ch;
		@(posedge mclk);
		#1;
		req_valid = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
	endtask

	task automatic stop_test();
		if (num_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================================
	// Clock, watchdog and main sequence
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	initial begin
		#5000;
		num_errors++;
		stop_test();
	end

	initial begin
		arst_n = 1'b0;
		burst_otf_en = 1'b1;
		req_valid = 1'b0;
		req_cmd = sdram_cmd_pkg::cmd_none;
		req_bank = 3'h0;
		req_addr = 13'h0123;
		req_auto_precharge = 1'b0;
		req_chop = 1'b0;
		req_lane_mask = 2'h1;
		repeat (2) @(posedge mclk);
		#1;
		arst_n = 1'b1;
		issue(sdram_cmd_pkg::cmd_wake, 3'h0, 1'b0, 1'b0);
		foreach (rows[i]) begin
			issue(rows[i].c, rows[i].b, rows[i].ap, rows[i].ch);
			check(cmd, rows[i].bad ? sdram_cmd_pkg::cmd_illegal
				: rows[i].c);
			check(cmd_valid, 1'b1);
			if (rows[i].c inside {sdram_cmd_pkg::cmd_read,
				sdram_cmd_pkg::cmd_write}) begin
				check(cmd_auto_precharge, rows[i].ap);
				check(cmd_chopped_four_beat_burst, rows[i].ch);
				check(cmd_bank, rows[i].b);
			end
			if (rows[i].c == sdram_cmd_pkg::cmd_write)
				check(write_lane_enable, 2'h2);
			if (rows[i].c == sdram_cmd_pkg::cmd_activate) begin
				check(open_row[rows[i].b], req_addr);
				check(cmd_addr, req_addr);
			end
		end
		check(bank_active, 8'h00);
		issue(sdram_cmd_pkg::cmd_activate, 3'h6, 1'b0, 1'b0);
		check(bank_active, 8'h40);
		// Chop request ignored while on-the-fly selection is off
		burst_otf_en = 1'b0;
		issue(sdram_cmd_pkg::cmd_read, 3'h6, 1'b0, 1'b1);
		check(cmd, sdram_cmd_pkg::cmd_read);
		check(cmd_chopped_four_beat_burst, 1'b0);
		burst_otf_en = 1'b1;
		req_lane_mask = 2'h2;
		repeat (4) @(posedge mclk);
		#1;
		check(write_lane_enable, 2'h1);
		check(cmd_valid, 1'b0);
		check(bank_active, 8'h40);
		issue(sdram_cmd_pkg::cmd_precharge, 3'h6, 1'b0, 1'b0);
		check(bank_active, 8'h00);
		check(bank_ready, 8'hbf);
		repeat (sdram_cmd_pkg::precharge_cycles - 1) @(posedge mclk);
		#1;
		check(bank_ready, 8'hbf);
		@(posedge mclk);
		#1;
		check(bank_ready, 8'hff);
		for (int i = 0; i < 4; i++) begin
			issue(lp[i], 3'h0, 1'b0, 1'b0);
			check(power_state, lps[i]);
		end
		issue(sdram_cmd_pkg::cmd_activate, 3'h1, 1'b0, 1'b0);
		arst_n = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		check(bank_active, 8'h00);
		check(cmd_valid, 1'b0);
		arst_n = 1'b1;
		issue(sdram_cmd_pkg::cmd_wake, 3'h0, 1'b0, 1'b0);
		issue(sdram_cmd_pkg::cmd_activate, 3'h0, 1'b0, 1'b0);
		check(bank_active, 8'h01);
		stop_test();
	end
endmodule // tb_top
